//--- design/pms_pkg.sv
// Constants shared by the proximity measurement sequencer files.
// Assumes a 100 MHz system clock on aclk.
package pms_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_NS        = 31250;
    localparam int TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
    localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_COMMAND  = 8'h04;
    localparam logic [7:0] OFS_PS_RATE  = 8'h08;
    localparam logic [7:0] OFS_ALS_RATE = 8'h0c;
    localparam logic [7:0] OFS_LED_SEL  = 8'h10;
    localparam logic [7:0] OFS_LED_CUR  = 8'h14;
    localparam logic [7:0] OFS_ADC_CFG  = 8'h18;
    localparam logic [7:0] OFS_THR_EN   = 8'h1c;
    localparam logic [7:0] OFS_THR0     = 8'h20;
    localparam logic [7:0] OFS_THR1     = 8'h24;
    localparam logic [7:0] OFS_THR2     = 8'h28;
    localparam logic [7:0] OFS_RES0     = 8'h2c;
    localparam logic [7:0] OFS_RES1     = 8'h30;
    localparam logic [7:0] OFS_RES2     = 8'h34;
    localparam logic [7:0] OFS_ALS_RES  = 8'h38;
    localparam logic [7:0] OFS_IRQ_ST   = 8'h3c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h40;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_PS_AUTO   = 3;
    localparam int CTRL_ALS_AUTO  = 4;
    localparam int CTRL_THR_ONLY  = 5;
    localparam int CTRL_SET_IRQ   = 6;
    localparam int RESP_OVF       = 0;
    localparam int RESP_BUSY      = 1;
    localparam int RESP_INT_LINE  = 2;
    localparam int IRQ_PS_MEAS    = 0;
    localparam int IRQ_PS_SET     = 1;
    localparam int IRQ_THR0       = 2;
    localparam int IRQ_ALS        = 5;
    localparam logic [7:0]  CTRL_RST     = 8'h07;
    localparam logic [8:0]  LED_SEL_RST  = 9'h111;
    localparam logic [11:0] LED_CUR_RST  = 12'h111;
    localparam logic [11:0] OVF_VALUE    = 12'hfff;

    // ------------------------------------------------------------
    // Commands and states
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_NOP       = 8'h00;
    localparam logic [7:0] CMD_PS_FORCE  = 8'h01;
    localparam logic [7:0] CMD_ALS_FORCE = 8'h02;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_ISSUE    = 2'b01,
        ST_PS_WAIT  = 2'b11,
        ST_ALS_WAIT = 2'b10
    } pms_state_type;

endpackage

//--- design/pms_conv_if.sv
// Request and result signals between the sequencer and its conversion unit.
// Both ends run on the same clock.
`timescale 1ns/1ps
interface pms_conv_if;
    logic        req;
    logic [2:0]  leds;
    logic [2:0]  gain;
    logic        range;
    logic        done;
    logic [15:0] result;
    logic        ovf;
    modport ctrl (output req, leds, gain, range, input done, result, ovf);
    modport conv (input req, leds, gain, range, output done, result, ovf);
endinterface

//--- design/pms_conv.sv
// One ADC conversion with its LED drivers switched on.
// Assumes the ADC runs on aclk and answers each start with one done pulse.
`timescale 1ns/1ps
module pms_conv
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    pms_conv_if.conv         cv,
    output      logic        adc_start,
    output      logic [2:0]  adc_gain,
    output      logic        adc_range,
    input  wire logic        adc_done,
    input  wire logic [15:0] adc_data,
    input  wire logic        adc_overflow,
    output      logic [2:0]  led_en
);
    typedef struct packed {
        logic        busy;
        logic        start;
        logic [2:0]  leds;
        logic [2:0]  gain;
        logic        range;
        logic        done;
        logic [15:0] result;
        logic        ovf;
    } pms_conv_state_type;

    pms_conv_state_type s;
    pms_conv_state_type next_s;

    always_comb
    begin
        next_s = s;
        next_s.start = 1'b0;
        next_s.done = 1'b0;
        if (!s.busy && cv.req)
        begin
            next_s.busy = 1'b1;
            next_s.start = 1'b1;
            next_s.leds = cv.leds;
            next_s.gain = cv.gain;
            next_s.range = cv.range;
        end
        else if (s.busy && adc_done)
        begin
            next_s.busy = 1'b0;
            next_s.leds = 3'h0;
            next_s.done = 1'b1;
            next_s.ovf = adc_overflow;
            next_s.result = adc_overflow ? {4'h0, pms_pkg::OVF_VALUE} : adc_data;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s <= '0;
        else
            s <= next_s;
    end

    assign adc_start = s.start;
    assign adc_gain  = s.gain;
    assign adc_range = s.range;
    assign led_en    = s.leds;
    assign cv.done   = s.done;
    assign cv.result = s.result;
    assign cv.ovf    = s.ovf;
endmodule

//--- design/pms_interval.sv
// Interval counter for autonomous measurements.
// Counts tick pulses; a period of zero stops it.
`timescale 1ns/1ps
module pms_interval
#(
    parameter int WIDTH = 16
)
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             tick,
    input  wire logic [WIDTH-1:0] period,
    output      logic             due
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             due;
    } pms_interval_state_type;

    pms_interval_state_type s;
    pms_interval_state_type next_s;

    always_comb
    begin
        next_s = s;
        next_s.due = 1'b0;
        if (period == '0)
            next_s.cnt = '0;
        else if (tick)
        begin
            if (s.cnt + WIDTH'(1) >= period)
            begin
                next_s.cnt = '0;
                next_s.due = 1'b1;
            end
            else
                next_s.cnt = s.cnt + WIDTH'(1);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s <= '0;
        else
            s <= next_s;
    end

    assign due = s.due;
endmodule

//--- design/pms_top.sv
// Proximity measurement sequencer: AXI4-Lite registers, measurement
// sequencing, threshold compare and interrupt.
// Assumes ADC and LED drivers on aclk; int_i comes from the shared pin.
//
// Function
// - Operating state set only through host registers
// - Host command starts single proximity or ambient measurement
// - Autonomous mode repeats measurements at programmed interval
// - Autonomous interrupt per measurement or threshold only
// - Up to three conversions, only enabled channels
// - Per-conversion ADC settings are programmable
// - Per-conversion LED driver selection, any combination
// - Reset default enables exactly one LED each
// - Optional per-channel threshold compare, notify on crossing
// - Optional interrupt after complete set of conversions
// - Three LED driver outputs provided
// - Independent run-time LED current per driver
// - Pending interrupt asserted on open-drain output
// - Overflow flagged in response, result reads 0xFFF
// - Overflow flag held until no-operation command
`timescale 1ns/1ps
module pms_top
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output      logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output      logic        s_axi_wready,
    output      logic [1:0]  s_axi_bresp,
    output      logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output      logic        s_axi_arready,
    output      logic [31:0] s_axi_rdata,
    output      logic [1:0]  s_axi_rresp,
    output      logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output      logic        adc_start,
    output      logic [2:0]  adc_gain,
    output      logic        adc_range,
    input  wire logic        adc_done,
    input  wire logic [15:0] adc_data,
    input  wire logic        adc_overflow,
    output      logic [2:0]  led_en,
    output      logic [11:0] led_current,
    input  wire logic        int_i,
    output      logic        int_o,
    output      logic        int_oe
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pms_pkg::pms_state_type st;
        logic [1:0]  ch;
        logic        pend_ps;
        logic        pend_als;
        logic        req;
        logic [2:0]  cv_leds;
        logic [2:0]  cv_gain;
        logic        cv_range;
        logic [7:0]  ctrl;
        logic [15:0] ps_rate;
        logic [15:0] als_rate;
        logic [8:0]  led_sel;
        logic [11:0] led_cur;
        logic [15:0] adc_cfg;
        logic [2:0]  thr_en;
        logic [47:0] thr;
        logic [47:0] ps_res;
        logic [15:0] als_res;
        logic [2:0]  above;
        logic        ovf;
        logic [5:0]  irq_st;
        logic [5:0]  irq_mask;
        logic        int_oe;
        logic [11:0] pre;
        logic        tick;
        logic [1:0]  int_sync;
        logic        aw_ok;
        logic        w_ok;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pms_top_state_type;

    pms_top_state_type s;
    pms_top_state_type next_s;

    pms_conv_if cv ();
    logic ps_due;
    logic als_due;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [32:0] pms_read(input pms_top_state_type r,
                                             input logic [7:0] a);
        logic [32:0] v;
        v = {1'b1, 32'h0};
        case (a)
            pms_pkg::OFS_CTRL:     v[7:0] = r.ctrl;
            pms_pkg::OFS_COMMAND:
            begin
                v[pms_pkg::RESP_OVF] = r.ovf;
                v[pms_pkg::RESP_BUSY] = (r.st != pms_pkg::ST_IDLE);
                v[pms_pkg::RESP_INT_LINE] = r.int_sync[1];
            end
            pms_pkg::OFS_PS_RATE:  v[15:0] = r.ps_rate;
            pms_pkg::OFS_ALS_RATE: v[15:0] = r.als_rate;
            pms_pkg::OFS_LED_SEL:  v[8:0] = r.led_sel;
            pms_pkg::OFS_LED_CUR:  v[11:0] = r.led_cur;
            pms_pkg::OFS_ADC_CFG:  v[15:0] = r.adc_cfg;
            pms_pkg::OFS_THR_EN:   v[2:0] = r.thr_en;
            pms_pkg::OFS_THR0:     v[15:0] = r.thr[15:0];
            pms_pkg::OFS_THR1:     v[15:0] = r.thr[31:16];
            pms_pkg::OFS_THR2:     v[15:0] = r.thr[47:32];
            pms_pkg::OFS_RES0:     v[15:0] = r.ps_res[15:0];
            pms_pkg::OFS_RES1:     v[15:0] = r.ps_res[31:16];
            pms_pkg::OFS_RES2:     v[15:0] = r.ps_res[47:32];
            pms_pkg::OFS_ALS_RES:  v[15:0] = r.als_res;
            pms_pkg::OFS_IRQ_ST:   v[5:0] = r.irq_st;
            pms_pkg::OFS_IRQ_MASK: v[5:0] = r.irq_mask;
            default:               v[32] = 1'b0;
        endcase
        return v;
    endfunction

    function automatic logic [31:0] pms_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  strb);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                v[8*i +: 8] = wd[8*i +: 8];
        return v;
    endfunction

    // Returns {found, index} of the first enabled channel after 'from', or from channel 0 when 'first' is set
    function automatic logic [2:0] pms_next_ch(input logic [2:0] list,
                                               input logic [1:0] from,
                                               input logic       first);
        logic [2:0] v;
        v = 3'h0;
        for (int i = 2; i >= 0; i--)
            if (list[i] && (first || 2'(i) > from))
                v = {1'b1, 2'(i)};
        return v;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [32:0] rd;
        logic [31:0] wd;
        logic [31:0] clr;
        logic [2:0]  nx;
        logic [5:0]  ev;
        logic        ovf_set;
        logic        abv;
        rd = '0;
        wd = '0;
        clr = '0;
        nx = '0;
        ev = '0;
        ovf_set = 1'b0;
        abv = 1'b0;
        next_s = s;
        next_s.req = 1'b0;
        next_s.tick = 1'b0;
        next_s.int_sync = {s.int_sync[0], int_i};

        // Measurement interval prescaler
        if (s.pre == pms_pkg::TICK_LAST)
        begin
            next_s.pre = '0;
            next_s.tick = 1'b1;
        end
        else
            next_s.pre = s.pre + 12'h1;

        // Sequencer
        case (s.st)
            pms_pkg::ST_IDLE:
            begin
                if (s.pend_ps)
                begin
                    next_s.pend_ps = 1'b0;
                    nx = pms_next_ch(s.ctrl[2:0], 2'h0, 1'b1);
                    if (nx[2])
                    begin
                        next_s.ch = nx[1:0];
                        next_s.st = pms_pkg::ST_ISSUE;
                    end
                end
                else if (s.pend_als)
                begin
                    next_s.pend_als = 1'b0;
                    next_s.req = 1'b1;
                    next_s.cv_leds = 3'h0;
                    next_s.cv_gain = s.adc_cfg[14:12];
                    next_s.cv_range = s.adc_cfg[15];
                    next_s.st = pms_pkg::ST_ALS_WAIT;
                end
            end
            pms_pkg::ST_ISSUE:
            begin
                next_s.req = 1'b1;
                next_s.cv_leds = s.led_sel[3*s.ch +: 3];
                next_s.cv_gain = s.adc_cfg[4*s.ch +: 3];
                next_s.cv_range = s.adc_cfg[4*s.ch + 3];
                next_s.st = pms_pkg::ST_PS_WAIT;
            end
            pms_pkg::ST_PS_WAIT:
            begin
                if (cv.done)
                begin
                    next_s.ps_res[16*s.ch +: 16] = cv.result;
                    ovf_set = cv.ovf;
                    abv = cv.result > s.thr[16*s.ch +: 16];
                    next_s.above[s.ch] = abv;
                    if (s.thr_en[s.ch] && abv != s.above[s.ch])
                        ev[pms_pkg::IRQ_THR0 + s.ch] = 1'b1;
                    if (!s.ctrl[pms_pkg::CTRL_THR_ONLY])
                        ev[pms_pkg::IRQ_PS_MEAS] = 1'b1;
                    nx = pms_next_ch(s.ctrl[2:0], s.ch, 1'b0);
                    if (nx[2])
                    begin
                        next_s.ch = nx[1:0];
                        next_s.st = pms_pkg::ST_ISSUE;
                    end
                    else
                    begin
                        ev[pms_pkg::IRQ_PS_SET] = s.ctrl[pms_pkg::CTRL_SET_IRQ];
                        next_s.st = pms_pkg::ST_IDLE;
                    end
                end
            end
            pms_pkg::ST_ALS_WAIT:
            begin
                if (cv.done)
                begin
                    next_s.als_res = cv.result;
                    ovf_set = cv.ovf;
                    ev[pms_pkg::IRQ_ALS] = 1'b1;
                    next_s.st = pms_pkg::ST_IDLE;
                end
            end
            default: next_s.st = pms_pkg::ST_IDLE;
        endcase

        // Autonomous triggers
        if (ps_due && s.ctrl[pms_pkg::CTRL_PS_AUTO])
            next_s.pend_ps = 1'b1;
        if (als_due && s.ctrl[pms_pkg::CTRL_ALS_AUTO])
            next_s.pend_als = 1'b1;

        // AXI write channel
        if (s_axi_awvalid && !s.aw_ok)
        begin
            next_s.aw_ok = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.w_ok)
        begin
            next_s.w_ok = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;
        if (s.aw_ok && s.w_ok && !s.bvalid)
        begin
            next_s.aw_ok = 1'b0;
            next_s.w_ok = 1'b0;
            next_s.bvalid = 1'b1;
            rd = pms_read(s, s.awaddr);
            next_s.bresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
            wd = pms_merge(rd[31:0], s.wdata, s.wstrb);
            clr = pms_merge(32'h0, s.wdata, s.wstrb);
            case (s.awaddr)
                pms_pkg::OFS_CTRL:     next_s.ctrl = wd[7:0];
                pms_pkg::OFS_COMMAND:
                begin
                    if (s.wstrb[0])
                    begin
                        case (s.wdata[7:0])
                            pms_pkg::CMD_NOP:       next_s.ovf = 1'b0;
                            pms_pkg::CMD_PS_FORCE:  next_s.pend_ps = 1'b1;
                            pms_pkg::CMD_ALS_FORCE: next_s.pend_als = 1'b1;
                            default:                next_s.ovf = s.ovf;
                        endcase
                    end
                end
                pms_pkg::OFS_PS_RATE:  next_s.ps_rate = wd[15:0];
                pms_pkg::OFS_ALS_RATE: next_s.als_rate = wd[15:0];
                pms_pkg::OFS_LED_SEL:  next_s.led_sel = wd[8:0];
                pms_pkg::OFS_LED_CUR:  next_s.led_cur = wd[11:0];
                pms_pkg::OFS_ADC_CFG:  next_s.adc_cfg = wd[15:0];
                pms_pkg::OFS_THR_EN:   next_s.thr_en = wd[2:0];
                pms_pkg::OFS_THR0:     next_s.thr[15:0] = wd[15:0];
                pms_pkg::OFS_THR1:     next_s.thr[31:16] = wd[15:0];
                pms_pkg::OFS_THR2:     next_s.thr[47:32] = wd[15:0];
                pms_pkg::OFS_IRQ_ST:   next_s.irq_st = s.irq_st & ~clr[5:0];
                pms_pkg::OFS_IRQ_MASK: next_s.irq_mask = wd[5:0];
                default:               next_s.bresp = RESP_SLVERR;
            endcase
        end

        // AXI read channel
        if (s.rvalid && s_axi_rready)
            next_s.rvalid = 1'b0;
        if (s_axi_arvalid && !s.rvalid)
        begin
            rd = pms_read(s, s_axi_araddr);
            next_s.rvalid = 1'b1;
            next_s.rdata = rd[31:0];
            next_s.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
        end

        // Events win over clears in the same cycle
        if (ovf_set)
            next_s.ovf = 1'b1;
        next_s.irq_st = next_s.irq_st | ev;
        next_s.int_oe = |(next_s.irq_st & next_s.irq_mask);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.ctrl <= pms_pkg::CTRL_RST;
            s.led_sel <= pms_pkg::LED_SEL_RST;
            s.led_cur <= pms_pkg::LED_CUR_RST;
        end
        else
            s <= next_s;
    end

    // ------------------------------------------------------------
    // Submodules and outputs
    // ------------------------------------------------------------
    assign cv.req   = s.req;
    assign cv.leds  = s.cv_leds;
    assign cv.gain  = s.cv_gain;
    assign cv.range = s.cv_range;

    pms_conv u_conv
    (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .cv           (cv),
        .adc_start    (adc_start),
        .adc_gain     (adc_gain),
        .adc_range    (adc_range),
        .adc_done     (adc_done),
        .adc_data     (adc_data),
        .adc_overflow (adc_overflow),
        .led_en       (led_en)
    );

    pms_interval #(.WIDTH(16)) u_ps_interval
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (s.tick),
        .period  (s.ps_rate),
        .due     (ps_due)
    );

    pms_interval #(.WIDTH(16)) u_als_interval
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (s.tick),
        .period  (s.als_rate),
        .due     (als_due)
    );

    assign s_axi_awready = !s.aw_ok;
    assign s_axi_wready  = !s.w_ok;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;
    assign led_current   = s.led_cur;
    assign int_o         = 1'b0;
    assign int_oe        = s.int_oe;
endmodule

//--- verif/pms_top_monitor.sv
// Port checker for pms_top.
// Bound to every pms_top instance; sees top-level ports only.
`timescale 1ns/1ps
module pms_top_monitor
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       adc_start,
    input wire logic [2:0] adc_gain,
    input wire logic       adc_range,
    input wire logic       adc_done,
    input wire logic [2:0] led_en,
    input wire logic       int_o
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
sequence s_conv_end;
    adc_done ##1 (led_en == 3'h0);
endsequence
property p_start_one; adc_start |=> !adc_start; endproperty
a_start_one: assert property (p_start_one) else $error("adc_start too long");
property p_gap; adc_done |=> !adc_start; endproperty
a_gap: assert property (p_gap) else $error("start right after done");
property p_led_off; adc_done && led_en != 3'h0 |-> s_conv_end; endproperty
a_led_off: assert property (p_led_off) else $error("led_en not off");
property p_led_hold; led_en != 3'h0 && !adc_done |=> $stable(led_en); endproperty
a_led_hold: assert property (p_led_hold) else $error("led_en moved");
property p_cfg_hold; adc_start ##1 !adc_done |-> $stable(adc_gain) && $stable(adc_range); endproperty
a_cfg_hold: assert property (p_cfg_hold) else $error("adc settings moved");
property p_int_low; int_o == 1'b0; endproperty
a_int_low: assert property (p_int_low) else $error("int_o not low");
property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
property p_rd_ready; s_axi_rvalid |-> !s_axi_arready; endproperty
a_rd_ready: assert property (p_rd_ready) else $error("arready during rvalid");
endmodule
bind pms_top pms_top_monitor u_mon (.*);

//--- verif/pms_adc_model.sv
// ADC stand-in: answers each adc_start with one adc_done pulse.
// Runs on aclk; logs LED and gain seen at each start.
`timescale 1ns/1ps
module pms_adc_model
(
    input  wire logic        aclk,
    input  wire logic        adc_start,
    input  wire logic [2:0]  adc_gain,
    input  wire logic        adc_range,
    input  wire logic [2:0]  led_en,
    input  wire logic [3:0]  ovf_at,
    output      logic        adc_done = 1'b0,
    output      logic [15:0] adc_data = 16'h5a5a,
    output      logic        adc_overflow = 1'b0
);
int n = 0;
int wt = -1;
logic [2:0] led_log [16];
logic [3:0] gain_log [16];
always @(posedge aclk)
begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    adc_overflow <= ~adc_overflow;
    if (adc_start)
    begin
        led_log[n] <= led_en;
        gain_log[n] <= {adc_range, adc_gain};
        wt <= (n % 2) ? 8 : 2;
    end
    else if (wt == 0)
    begin
        adc_done <= 1'b1;
        adc_data <= 16'h0010 + 16'(n);
        adc_overflow <= (ovf_at == 4'(n));
        n <= n + 1;
        wt <= -1;
    end
    else if (wt > 0)
        wt <= wt - 1;
end
endmodule

//--- verif/test_proximity_measure_sequencer.sv
// Bench for pms_top over AXI4-Lite with an ADC stand-in.
// Assumes a 100 MHz aclk.
`timescale 1ns/1ps
module test_proximity_measure_sequencer;
logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
logic s_axi_arready, s_axi_rvalid, adc_start, adc_range, adc_done, adc_overflow, int_o, int_oe;
logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
logic [3:0] s_axi_wstrb = 4'hf, ovf_at = 4'hf;
logic [1:0] s_axi_bresp, s_axi_rresp, rr, rb;
logic [2:0] adc_gain, led_en;
logic [15:0] adc_data;
logic [11:0] led_current;
wire int_i = !int_oe;
int errors = 0, comparisons = 0, cyc = 0;
pms_top u_dut (.*);
pms_adc_model u_adc (.*);
initial forever #5 aclk = ~aclk;
task automatic finish_test;
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
always @(posedge aclk)
begin
    cyc++;
    if (cyc == 20000)
    begin
        errors++;
        finish_test;
    end
end
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
        errors++;
        $display("ERROR %s expected %h seen %h", nm, e, g);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    fork
        begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 0; end
        begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 0; end
    join
    while (!s_axi_bvalid) @(posedge aclk);
    rb = s_axi_bresp;
    s_axi_bready <= 0;
endtask
task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rv = s_axi_rdata; rr = s_axi_rresp; s_axi_rready <= 0;
    chk(nm, e, rv);
endtask
task automatic wait_n(input int k);
    while (u_adc.n < k) @(posedge aclk);
    repeat (4) @(posedge aclk);
endtask
initial
begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rchk("ctrl", pms_pkg::OFS_CTRL, 32'h07);
    rchk("led_sel", pms_pkg::OFS_LED_SEL, 32'h111);
    rchk("led_cur", pms_pkg::OFS_LED_CUR, 32'h111);
    rchk("unmapped", 8'hfc, 32'h0);
    chk("unmapped_resp", 32'h2, 32'(rr));
    wr(8'hfc, 32'h0);
    chk("unmapped_wresp", 32'h2, 32'(rb));
    wr(pms_pkg::OFS_LED_CUR, 32'h321);
    repeat (2) @(posedge aclk);
    chk("led_current", 32'h321, 32'(led_current));
    wr(pms_pkg::OFS_LED_SEL, 32'h054);
    wr(pms_pkg::OFS_ADC_CFG, 32'ha53);
    wr(pms_pkg::OFS_THR0, 32'h0f);
    wr(pms_pkg::OFS_THR_EN, 32'h1);
    wr(pms_pkg::OFS_IRQ_MASK, 32'h3f);
    wr(pms_pkg::OFS_CTRL, 32'h47);
    ovf_at <= 4'h1;
    wr(pms_pkg::OFS_COMMAND, 32'(pms_pkg::CMD_PS_FORCE));
    wait_n(3);
    for (int k = 0; k < 3; k++)
    begin
        chk("led", 32'(3'h4 >> k), 32'(u_adc.led_log[k]));
        chk("gain", (32'ha53 >> (4 * k)) & 32'hf, 32'(u_adc.gain_log[k]));
    end
    rchk("res0", pms_pkg::OFS_RES0, 32'h10);
    rchk("res1", pms_pkg::OFS_RES1, 32'hfff);
    rchk("res2", pms_pkg::OFS_RES2, 32'h12);
    rchk("irq", pms_pkg::OFS_IRQ_ST, 32'h07);
    chk("int_oe", 32'h1, 32'(int_oe));
    rchk("resp", pms_pkg::OFS_COMMAND, 32'h1);
    ovf_at <= 4'hf;
    wr(pms_pkg::OFS_COMMAND, 32'(pms_pkg::CMD_ALS_FORCE));
    wait_n(4);
    rchk("als", pms_pkg::OFS_ALS_RES, 32'h13);
    rchk("ovf_held", pms_pkg::OFS_COMMAND, 32'h1);
    wr(pms_pkg::OFS_COMMAND, 32'(pms_pkg::CMD_NOP));
    rchk("ovf_clr", pms_pkg::OFS_COMMAND, 32'h0);
    wr(pms_pkg::OFS_IRQ_ST, 32'h3f);
    repeat (2) @(posedge aclk);
    chk("int_clr", 32'h0, 32'(int_oe));
    wr(pms_pkg::OFS_PS_RATE, 32'h1);
    wr(pms_pkg::OFS_CTRL, 32'h09);
    repeat (7000) @(posedge aclk);
    wr(pms_pkg::OFS_CTRL, 32'h0);
    chk("auto_runs", 32'h1, 32'(u_adc.n >= 6));
    rchk("auto_irq", pms_pkg::OFS_IRQ_ST, 32'h01);
    repeat (20) @(posedge aclk);
    wr(pms_pkg::OFS_THR0, 32'hffff);
    wr(pms_pkg::OFS_ALS_RATE, 32'h1);
    wr(pms_pkg::OFS_IRQ_ST, 32'h3f);
    wr(pms_pkg::OFS_CTRL, 32'h39);
    repeat (3500) @(posedge aclk);
    wr(pms_pkg::OFS_CTRL, 32'h0);
    rchk("thr_only_irq", pms_pkg::OFS_IRQ_ST, 32'h24);
    finish_test;
end
endmodule
